/* logic/flc_lock_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - lock opcode plus address sets block lock
// - unlock opcode clears addressed block lock
// - all lock bits set after reset
// - individual locks active only when scheme bit set
// - 94 lock bits, 4 KB ends, 64 KB middle
// - global lock sets all, unlock clears all
// - both read-lock opcodes behave identically
// - lock field shifted out MSB first
// - field LSB one means block locked
// - power-down with depth bit enters deep sleep
// - power-down without depth bit enters ultra sleep
// - legacy opcode always enters ultra sleep
// - resume from deep returns idle, SRAM kept
// - resume from ultra runs internal reset
// - chip select release never wakes device
// - reset pair wakes deep, ignored in ultra
// - terminate never leaves power down
// - hardware or jedec reset wakes, SRAM lost
// - resets stop operation and reset; terminate halts
// - applies to every program and erase opcode
// - scheme bit zero uses standard protection
module flc_lock_power_ctrl
  import flc_pkg::*;
#(
  parameter int unsigned OP_CYCLES_P = OP_CYCLES,
  parameter int unsigned WAKE_CYCLES_P = WAKE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic hw_reset_n,
  input wire logic jedec_reset,
  input wire logic std_block_protected,
  output logic array_start,
  output logic array_busy,
  output logic sram_valid,
  output logic deep_sleep_mode,
  output logic ultra_sleep_mode
);
  // ************************************************************
  // declarations
  // ************************************************************
  flc_lock_if lkb ();
  logic sck_d_r;
  logic cs_d_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic [5:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic [7:0] out_r;
  logic rd_frame;
  logic protection_scheme_select_r;
  logic hwrst_en_r;
  logic power_down_depth_select_r;
  logic reject_r;
  logic halted_r;
  logic rst_en_r;
  logic sram_valid_r;
  flc_pwr_t pwr_r;
  flc_pwr_t pwr_nxt;
  logic [15:0] wake_cnt_r;
  logic ready_state;
  logic do_lock_one;
  logic do_unlock_one;
  logic do_lock_all;
  logic do_unlock_all;
  logic do_pd;
  logic ultra_sel;
  logic do_resume;
  logic do_sw_reset;
  logic do_term;
  logic do_pe;
  logic target_protected;
  logic hw_rst_evt;
  logic ext_reset;
  logic wake_done;
  logic dev_reset;
  logic apb_wr;
  logic apb_mapped;
  logic [31:0] rdata_nxt;

  // ************************************************************
  // serial front end
  // ************************************************************
  // pins are already in the pclk domain, so plain edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= spi_sck;
      cs_d_r <= spi_cs_n;
    end
  end

  assign sck_rise = spi_sck & ~sck_d_r & ~spi_cs_n;
  assign sck_fall = ~spi_sck & sck_d_r & ~spi_cs_n;
  assign cs_rise = spi_cs_n & ~cs_d_r;

  // bit count saturates so long data phases cannot wrap into a match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 6'h00;
    end else if (cs_rise) begin
      bit_cnt_r <= 6'h00;
    end else if (sck_rise && bit_cnt_r != 6'h3f) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // opcode and address capture, mode 0 sampling on rising sck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 8'h00;
      opcode_r <= 8'h00;
      addr_r <= 24'h000000;
    end else if (sck_rise) begin
      shift_r <= {shift_r[6:0], spi_si};
      if (bit_cnt_r == 6'h07) begin
        opcode_r <= {shift_r[6:0], spi_si};
      end
      if (bit_cnt_r >= 6'h08 && bit_cnt_r < 6'h20) begin
        addr_r <= {addr_r[22:0], spi_si};
      end
    end
  end

  assign rd_frame = (opcode_r == OP_RD_LOCK_A || opcode_r == OP_RD_LOCK_B) &&
    pwr_r == PWR_IDLE;

  // lock field loads at the first falling edge after the address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 8'h00;
    end else if (sck_fall && rd_frame && bit_cnt_r == 6'h20) begin
      out_r <= {7'h00, lkb.hit};
    end else if (sck_fall && bit_cnt_r > 6'h20) begin
      out_r <= {out_r[6:0], 1'b0};
    end
  end

  assign spi_so = out_r[7];
  // drive starts at the first fall after the address, not while sck is still high
  assign spi_so_oe = rd_frame & ~spi_cs_n & ((bit_cnt_r > 6'h20) |
    (bit_cnt_r == 6'h20 & ~sck_d_r & ~spi_sck));

  // ************************************************************
  // command decode at chip select release
  // ************************************************************
  assign ready_state = (pwr_r == PWR_IDLE) & ~array_busy;
  assign do_lock_one = cs_rise & ready_state & opcode_r == OP_LOCK_ONE & bit_cnt_r == 6'h20;
  assign do_unlock_one = cs_rise & ready_state & opcode_r == OP_UNLOCK_ONE & bit_cnt_r == 6'h20;
  assign do_lock_all = cs_rise & ready_state & opcode_r == OP_LOCK_ALL & bit_cnt_r == 6'h08;
  assign do_unlock_all = cs_rise & ready_state & opcode_r == OP_UNLOCK_ALL & bit_cnt_r == 6'h08;
  assign do_pd = cs_rise & ready_state & bit_cnt_r == 6'h08 &
    (opcode_r == OP_PWR_DOWN || opcode_r == OP_ULTRA_LEGACY);
  assign ultra_sel = (opcode_r == OP_ULTRA_LEGACY) | ~power_down_depth_select_r;
  assign do_resume = cs_rise & bit_cnt_r == 6'h08 & opcode_r == OP_RESUME &
    (pwr_r == PWR_DEEP || pwr_r == PWR_ULTRA);
  assign do_sw_reset = cs_rise & bit_cnt_r == 6'h08 & opcode_r == OP_RST_DEVICE & rst_en_r &
    (pwr_r == PWR_IDLE || pwr_r == PWR_DEEP);
  // terminate only halts, and only outside power down
  assign do_term = cs_rise & bit_cnt_r == 6'h08 & opcode_r == OP_TERMINATE &
    pwr_r == PWR_IDLE & array_busy;
  // program needs address plus at least one data byte
  assign do_pe = cs_rise & ready_state &
    ((flc_is_program(opcode_r) && bit_cnt_r >= 6'h28) ||
     (flc_is_erase(opcode_r) && bit_cnt_r == 6'h20) ||
     (flc_is_chip_erase(opcode_r) && bit_cnt_r == 6'h08));
  // with the scheme bit set, chip erase is refused while any single lock remains
  assign target_protected = protection_scheme_select_r ?
    (flc_is_chip_erase(opcode_r) ? lkb.any : lkb.hit) : std_block_protected;
  assign array_start = do_pe & ~target_protected;

  // enable half of the software reset pair, dropped by any other command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_en_r <= 1'b0;
    end else if (cs_rise && bit_cnt_r != 6'h00) begin
      rst_en_r <= (opcode_r == OP_RST_ENABLE) && bit_cnt_r == 6'h08 && pwr_r != PWR_ULTRA &&
        pwr_r != PWR_WAKE;
    end
  end

  // ************************************************************
  // reset sources
  // ************************************************************
  // the pin only counts once software has enabled it
  assign hw_rst_evt = ~hw_reset_n & hwrst_en_r;
  assign ext_reset = hw_rst_evt | jedec_reset;
  assign wake_done = (pwr_r == PWR_WAKE) && wake_cnt_r == 16'h0000;
  assign dev_reset = ext_reset | do_sw_reset | wake_done;

  // ************************************************************
  // lock bank and operation timer
  // ************************************************************
  assign lkb.addr = addr_r;
  assign lkb.set_one = do_lock_one;
  assign lkb.clr_one = do_unlock_one;
  assign lkb.set_all = do_lock_all | dev_reset;
  assign lkb.clr_all = do_unlock_all;

  flc_lock_bank #(
    .NBITS(LOCK_BITS)
  ) u_bank (
    .clk(pclk),
    .rst_n(presetn),
    .lk(lkb.bank)
  );

  flc_op_timer #(
    .CYCLES(OP_CYCLES_P)
  ) u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .start(array_start),
    .halt(do_term | dev_reset),
    .busy(array_busy)
  );

  // ************************************************************
  // power state
  // ************************************************************
  // external resets override; cs release alone never moves the state
  always_comb begin
    pwr_nxt = pwr_r;
    if (ext_reset) begin
      pwr_nxt = PWR_IDLE;
    end else begin
      unique case (pwr_r)
        PWR_IDLE: begin
          if (do_pd) begin
            pwr_nxt = ultra_sel ? PWR_ULTRA : PWR_DEEP;
          end
        end
        PWR_DEEP: begin
          if (do_resume || do_sw_reset) begin
            pwr_nxt = PWR_IDLE;
          end
        end
        PWR_ULTRA: begin
          if (do_resume) begin
            pwr_nxt = PWR_WAKE;
          end
        end
        PWR_WAKE: begin
          if (wake_done) begin
            pwr_nxt = PWR_IDLE;
          end
        end
        default: pwr_nxt = PWR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= PWR_IDLE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // internal reset sequence length after an ultra sleep resume
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_r <= 16'h0000;
    end else if (pwr_r != PWR_WAKE) begin
      wake_cnt_r <= 16'(WAKE_CYCLES_P - 1);
    end else if (wake_cnt_r != 16'h0000) begin
      wake_cnt_r <= wake_cnt_r - 16'h0001;
    end
  end

  // buffer contents survive deep sleep and soft reset only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sram_valid_r <= 1'b0;
    end else if (ext_reset || (do_pd && ultra_sel) || pwr_r == PWR_WAKE) begin
      sram_valid_r <= 1'b0;
    end else if (array_start && flc_is_program(opcode_r)) begin
      sram_valid_r <= 1'b1;
    end
  end

  assign sram_valid = sram_valid_r;
  assign deep_sleep_mode = (pwr_r == PWR_DEEP);
  assign ultra_sleep_mode = (pwr_r == PWR_ULTRA);

  // ************************************************************
  // apb registers
  // ************************************************************
  assign apb_wr = psel & penable & pwrite;
  assign apb_mapped = paddr == REG_SR3 || paddr == REG_SR4 || paddr == REG_STATUS;
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~apb_mapped;

  // configuration bits are not touched by device resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protection_scheme_select_r <= SR3_SCHEME_RST;
      hwrst_en_r <= SR3_HWRST_EN_RST;
      power_down_depth_select_r <= SR4_DEPTH_RST;
    end else if (apb_wr && paddr == REG_SR3) begin
      protection_scheme_select_r <= pwdata[SR3_SCHEME_BIT];
      hwrst_en_r <= pwdata[SR3_HWRST_EN_BIT];
    end else if (apb_wr && paddr == REG_SR4) begin
      power_down_depth_select_r <= pwdata[SR4_DEPTH_BIT];
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject_r <= 1'b0;
      halted_r <= 1'b0;
    end else begin
      if (do_pe && target_protected) begin
        reject_r <= 1'b1;
      end else if (apb_wr && paddr == REG_STATUS && pwdata[ST_REJECT_BIT]) begin
        reject_r <= 1'b0;
      end
      if (do_term) begin
        halted_r <= 1'b1;
      end else if (apb_wr && paddr == REG_STATUS && pwdata[ST_HALTED_BIT]) begin
        halted_r <= 1'b0;
      end
    end
  end

  // read data is taken in the setup cycle so prdata comes from a flop
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (paddr == REG_SR3) begin
      rdata_nxt[SR3_SCHEME_BIT] = protection_scheme_select_r;
      rdata_nxt[SR3_HWRST_EN_BIT] = hwrst_en_r;
    end else if (paddr == REG_SR4) begin
      rdata_nxt[SR4_DEPTH_BIT] = power_down_depth_select_r;
    end else if (paddr == REG_STATUS) begin
      rdata_nxt[ST_BUSY_BIT] = array_busy;
      rdata_nxt[ST_DEEP_BIT] = deep_sleep_mode;
      rdata_nxt[ST_ULTRA_BIT] = ultra_sleep_mode;
      rdata_nxt[ST_WAKE_BIT] = (pwr_r == PWR_WAKE);
      rdata_nxt[ST_SRAM_BIT] = sram_valid_r;
      rdata_nxt[ST_REJECT_BIT] = reject_r;
      rdata_nxt[ST_HALTED_BIT] = halted_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_one_sets_a: assert property (do_lock_one && !ext_reset |=> lkb.hit)
    else $error("single lock did not set the addressed bit");
  unlock_one_clr_a: assert property (do_unlock_one && !ext_reset |=> !lkb.hit)
    else $error("single unlock did not clear the addressed bit");
  reset_locks_all_a: assert property (dev_reset |=> lkb.all)
    else $error("device reset left a block unlocked");
  global_unlock_a: assert property (do_unlock_all && !ext_reset |=> !lkb.any)
    else $error("global unlock left a lock bit set");
  std_scheme_a: assert property (
    do_pe && !protection_scheme_select_r && !std_block_protected |-> array_start)
    else $error("standard scheme blocked an open target");
  locked_refuse_a: assert property (
    do_pe && protection_scheme_select_r && lkb.hit |-> !array_start ##1 !array_busy)
    else $error("locked target started an operation");
  lock_field_lsb_a: assert property (
    rd_frame && sck_fall && bit_cnt_r == 6'h27 |=> spi_so == $past(lkb.hit))
    else $error("lock field lsb does not match lock bit");
  lock_field_msb_a: assert property (
    rd_frame && sck_fall && bit_cnt_r == 6'h20 |=> !spi_so && spi_so_oe)
    else $error("lock field msb not driven as zero");
  deep_entry_a: assert property (
    do_pd && !ultra_sel && !ext_reset |=> deep_sleep_mode && $stable(sram_valid))
    else $error("deep sleep entry wrong");
  ultra_entry_a: assert property (
    do_pd && ultra_sel && !ext_reset |=> ultra_sleep_mode && !sram_valid)
    else $error("ultra sleep entry wrong");
  deep_resume_a: assert property (
    deep_sleep_mode && do_resume && !ext_reset |=> pwr_r == PWR_IDLE && $stable(sram_valid))
    else $error("deep sleep resume wrong");
  cs_no_wake_a: assert property (
    deep_sleep_mode && cs_rise && !do_resume && !do_sw_reset && !ext_reset |=> deep_sleep_mode)
    else $error("chip select release woke deep sleep");
  ultra_hold_a: assert property (
    ultra_sleep_mode && !do_resume && !ext_reset |=> ultra_sleep_mode)
    else $error("ultra sleep left without resume or reset");
  ultra_resume_a: assert property (
    ultra_sleep_mode && do_resume && !ext_reset |=> pwr_r == PWR_WAKE ##1 !sram_valid)
    else $error("ultra resume skipped internal reset");
  terminate_halt_a: assert property (
    do_term && !ext_reset |=> !array_busy && pwr_r == PWR_IDLE && $stable(sram_valid) && halted_r)
    else $error("terminate did not halt operation");
endmodule
`default_nettype wire

/* logic/flc_pkg.sv */
`default_nettype none
// ************************************************************
// constants shared by the lock and power-down control
// ************************************************************
package flc_pkg;
  // serial opcodes
  localparam logic [7:0] OP_LOCK_ONE = 8'h36;
  localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
  localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
  localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
  localparam logic [7:0] OP_RD_LOCK_A = 8'h3c;
  localparam logic [7:0] OP_RD_LOCK_B = 8'h3d;
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_ULTRA_LEGACY = 8'h79;
  localparam logic [7:0] OP_RESUME = 8'hab;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DEVICE = 8'h99;
  localparam logic [7:0] OP_TERMINATE = 8'hf0;
  // apb register map and fields
  localparam logic [7:0] REG_SR3 = 8'h00;
  localparam logic [7:0] REG_SR4 = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int SR3_SCHEME_BIT = 2;
  localparam int SR3_HWRST_EN_BIT = 7;
  localparam int SR4_DEPTH_BIT = 7;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DEEP_BIT = 1;
  localparam int ST_ULTRA_BIT = 2;
  localparam int ST_WAKE_BIT = 3;
  localparam int ST_SRAM_BIT = 4;
  localparam int ST_REJECT_BIT = 5;
  localparam int ST_HALTED_BIT = 6;
  localparam logic SR3_SCHEME_RST = 1'b0;
  localparam logic SR3_HWRST_EN_RST = 1'b0;
  localparam logic SR4_DEPTH_RST = 1'b0;
  localparam int LOCK_BITS = 94;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int OP_TIME_NS = 50000;
  localparam int WAKE_TIME_NS = 1000;
  localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    PWR_IDLE = 4'b0001,
    PWR_DEEP = 4'b0010,
    PWR_ULTRA = 4'b0100,
    PWR_WAKE = 4'b1000
  } flc_pwr_t;
  // program opcodes taking an address and data
  function automatic logic flc_is_program(input logic [7:0] op);
    return op inside {8'h02, 8'haf, 8'had, 8'ha2, 8'h32, 8'h0a, 8'h88, 8'h9b};
  endfunction
  // erase opcodes taking an address
  function automatic logic flc_is_erase(input logic [7:0] op);
    return op inside {8'h81, 8'hdb, 8'h20, 8'h52, 8'hd8};
  endfunction
  function automatic logic flc_is_chip_erase(input logic [7:0] op);
    return op inside {8'h60, 8'hc7};
  endfunction
  // 4 KB granules in the end blocks, 64 KB granules between them
  function automatic logic [6:0] flc_lock_index(input logic [23:0] addr);
    logic [6:0] idx;
    idx = {1'b0, addr[21:16]} + 7'h1f;
    if (addr[21:16] == 6'h00) begin
      idx = {3'b000, addr[15:12]};
    end else if (addr[21:16] == 6'h3f) begin
      idx = {3'b001, addr[15:12]};
    end
    return idx;
  endfunction
endpackage
`default_nettype wire

/* logic/flc_lock_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// lock bank request and answer bundle
// ************************************************************
interface flc_lock_if;
  logic [23:0] addr;
  logic set_one;
  logic clr_one;
  logic set_all;
  logic clr_all;
  logic hit;
  logic any;
  logic all;
  modport ctl(output addr, set_one, clr_one, set_all, clr_all, input hit, any, all);
  modport bank(input addr, set_one, clr_one, set_all, clr_all, output hit, any, all);
endinterface
`default_nettype wire

/* logic/flc_lock_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// per-block lock bits
// ************************************************************
module flc_lock_bank
  import flc_pkg::*;
#(
  parameter int NBITS = LOCK_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  flc_lock_if.bank lk
);
  logic [NBITS-1:0] lock_r;
  logic [6:0] idx;

  assign idx = flc_lock_index(lk.addr);

  // global set beats global clear beats single updates
  for (genvar i = 0; i < NBITS; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lock_r[i] <= 1'b1;
      end else if (lk.set_all) begin
        lock_r[i] <= 1'b1;
      end else if (lk.clr_all) begin
        lock_r[i] <= 1'b0;
      end else if (idx == 7'(i)) begin
        if (lk.set_one) begin
          lock_r[i] <= 1'b1;
        end else if (lk.clr_one) begin
          lock_r[i] <= 1'b0;
        end
      end
    end
  end

  assign lk.hit = lock_r[idx];
  assign lk.any = |lock_r;
  assign lk.all = &lock_r;
endmodule
`default_nettype wire

/* logic/flc_op_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// self-timed program / erase duration
// ************************************************************
module flc_op_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic halt,
  output logic busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;

  // halt wins so a reset never leaves a stray operation running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (halt) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);
endmodule
`default_nettype wire

/* tb/flc_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// host spi controller model, mode 0
// ************************************************************
module flc_spi_host (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic [7:0] rd_byte
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rd_byte = 8'h00;
  end
  // n bits out msb first, then nrd bits in; two pclk per sck phase for the edge detector
  task automatic frame(input logic [39:0] bits, input int n, input int nrd);
    int i;
    @(posedge clk);
    cs_n <= 1'b0;
    for (i = 0; i < n + nrd; i++) begin
      @(posedge clk);
      si <= (i < n) ? bits[39 - i] : ~si; // dead bits toggle, never a stale level
      @(posedge clk);
      sck <= 1'b1;
      if (i >= n) begin
        // an undriven line reads as its pull-up level
        rd_byte <= {rd_byte[6:0], so_oe ? so : 1'b1};
      end
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/test_flc_lock_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench for lock and power-down control
// ************************************************************
module test_flc_lock_power_ctrl
  import flc_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hw_reset_n = 1'b1;
  logic jedec_reset = 1'b0;
  logic std_prot = 1'b0;
  logic [31:0] prdata, q;
  logic [7:0] rd;
  logic pready, pslverr, err, so, so_oe, cs_n, sck, si, start, busy, sram, deep, ultra;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #4 pclk = ~pclk;
  // short counts keep the run small; an operation still outlasts two short frames
  flc_lock_power_ctrl #(.OP_CYCLES_P(200), .WAKE_CYCLES_P(4)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_cs_n(cs_n),
    .spi_sck(sck), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .hw_reset_n(hw_reset_n),
    .jedec_reset(jedec_reset), .std_block_protected(std_prot), .array_start(start),
    .array_busy(busy), .sram_valid(sram), .deep_sleep_mode(deep), .ultra_sleep_mode(ultra));
  flc_spi_host i_host (.clk(pclk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .rd_byte(rd));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // look off the edge so flop updates have landed
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    #1;
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb: setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [7:0] c);
    i_host.frame({c, 32'h0}, 8, 0);
  endtask
  task automatic adr(input logic [7:0] c, input logic [23:0] a);
    i_host.frame({c, a, 8'h00}, 32, 0);
  endtask
  task automatic lk(input logic [7:0] c, input logic [23:0] a, input logic e);
    i_host.frame({c, a, 8'h00}, 32, 8);
    check("lock field", rd, {7'h0, e});
  endtask
  // hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    lk(OP_RD_LOCK_A, 24'h000000, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", {7'h0, err}, 8'h01);
    apb(1'b1, REG_SR3, 32'h84);
    adr(OP_UNLOCK_ONE, 24'h050000);
    lk(OP_RD_LOCK_B, 24'h05ffff, 1'b0);
    lk(OP_RD_LOCK_A, 24'h060000, 1'b1);
    adr(OP_UNLOCK_ONE, 24'h3f1000);
    lk(OP_RD_LOCK_A, 24'h3f1fff, 1'b0);
    lk(OP_RD_LOCK_A, 24'h3f2000, 1'b1);
    adr(OP_LOCK_ONE, 24'h050000);
    lk(OP_RD_LOCK_A, 24'h050000, 1'b1);
    i_host.frame({8'h02, 24'h050000, 8'ha5}, 40, 0);
    check("busy locked", {7'h0, busy}, 8'h00);
    apb(1'b0, REG_STATUS, 32'h0);
    check("reject", {7'h0, q[ST_REJECT_BIT]}, 8'h01);
    op(OP_UNLOCK_ALL);
    lk(OP_RD_LOCK_A, 24'h200000, 1'b0);
    adr(8'hd8, 24'h200000);
    check("busy erase", {7'h0, busy}, 8'h01);
    op(OP_TERMINATE);
    check("busy halted", {7'h0, busy}, 8'h00);
    apb(1'b0, REG_STATUS, 32'h0);
    check("halted", {7'h0, q[ST_HALTED_BIT]}, 8'h01);
    lk(OP_RD_LOCK_A, 24'h200000, 1'b0);
    apb(1'b1, REG_SR3, 32'h80);
    adr(8'h20, 24'h000000);
    op(OP_RST_ENABLE);
    op(OP_RST_DEVICE);
    check("busy reset", {7'h0, busy}, 8'h00);
    lk(OP_RD_LOCK_A, 24'h000000, 1'b1);
    i_host.frame({8'h02, 24'h050000, 8'ha5}, 40, 0);
    check("busy scheme0", {7'h0, busy}, 8'h01);
    op(OP_TERMINATE);
    std_prot <= 1'b1;
    adr(8'h20, 24'h000000);
    check("busy std", {7'h0, busy}, 8'h00);
    apb(1'b1, REG_SR4, 32'h80);
    std_prot <= 1'b0;
    op(OP_PWR_DOWN);
    check("deep", {7'h0, deep}, 8'h01);
    op(OP_TERMINATE);
    i_host.frame(40'h0, 0, 0);
    check("deep stays", {7'h0, deep}, 8'h01);
    op(OP_RESUME);
    check("resume", {6'h0, deep, sram}, 8'h01);
    op(OP_PWR_DOWN);
    op(OP_RST_ENABLE);
    op(OP_RST_DEVICE);
    check("pair deep", {6'h0, deep, sram}, 8'h01);
    op(OP_UNLOCK_ALL);
    apb(1'b1, REG_SR4, 32'h00);
    op(OP_PWR_DOWN);
    check("ultra", {6'h0, ultra, sram}, 8'h02);
    op(OP_RST_ENABLE);
    op(OP_RST_DEVICE);
    check("pair ultra", {7'h0, ultra}, 8'h01);
    op(OP_RESUME);
    repeat (8) @(posedge pclk);
    check("ultra wake", {7'h0, ultra}, 8'h00);
    lk(OP_RD_LOCK_A, 24'h100000, 1'b1);
    apb(1'b1, REG_SR4, 32'h80);
    op(OP_ULTRA_LEGACY);
    check("legacy", {6'h0, ultra, deep}, 8'h02);
    @(posedge pclk);
    jedec_reset <= 1'b1;
    @(posedge pclk);
    jedec_reset <= 1'b0;
    repeat (2) @(posedge pclk);
    check("jedec", {6'h0, ultra, sram}, 8'h00);
    op(OP_ULTRA_LEGACY);
    hw_reset_n <= 1'b0;
    repeat (2) @(posedge pclk);
    hw_reset_n <= 1'b1;
    repeat (2) @(posedge pclk);
    check("pin", {7'h0, ultra}, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
